/* File: rtl/media_pkg.sv */
// Shared constants, types and helpers for the MAC-side media link
`default_nettype none
package media_pkg;

  typedef enum logic [1:0] {
    MODE_MII   = 2'h0,
    MODE_RMII  = 2'h1,
    MODE_RGMII = 2'h2
  } macMode_t;

  typedef enum logic [1:0] {
    ST_SETTLE = 2'h0,
    ST_WAIT   = 2'h1,
    ST_LATCH  = 2'h3,
    ST_RUN    = 2'h2
  } strapState_t;

  localparam int REF_CLK_KHZ  = 50000;
  localparam int RATE_100_KHZ = 25000;
  localparam int RATE_10_KHZ  = 2500;

  localparam logic [3:0] HALF_100     = 4'(REF_CLK_KHZ / (2 * RATE_100_KHZ));
  localparam logic [3:0] HALF_10      = 4'(REF_CLK_KHZ / (2 * RATE_10_KHZ));
  localparam logic [3:0] RMII_STEP_10 = 4'(RATE_100_KHZ / RATE_10_KHZ);

  localparam logic [3:0] MII_LANES  = 4'hf;
  localparam logic [3:0] RMII_LANES = 4'h3;

  // Pin pulls seen while nobody drives, and the strap address reset value
  localparam logic [3:0] RXD_PULL    = 4'h0;
  localparam logic       COL_PULL    = 1'b1;
  localparam logic       TXCLK_PULL  = 1'b0;
  localparam logic [4:0] STRAP_RESET = 5'h00;

  // Link cycles the MAC end waits before driving its transmit clock
  localparam logic [2:0] MAC_START_WAIT = 3'h5;

  // Half-period end of the nibble clock divider
  function automatic logic divToggle(input logic [3:0] cnt, input logic speed100);
    return cnt == ((speed100 ? HALF_100 : HALF_10) - 4'h1);
  endfunction : divToggle

  // Dibit sample point in RMII
  function automatic logic rmiiTick(input logic [3:0] cnt, input logic speed100);
    return cnt == (speed100 ? 4'h0 : RMII_STEP_10 - 4'h1);
  endfunction : rmiiTick

endpackage : media_pkg
`default_nettype wire

/* File: rtl/media_link_if.sv */
// Pin bundle between the transceiver end and the MAC end
`default_nettype none
interface media_link_if (
  input wire logic refClk
);
  import media_pkg::*;

  logic       txClkPhy;
  logic       txClkPhyOe;
  logic       txClkMac;
  logic       txClkMacOe;
  logic       txClk;
  logic       txCtrl;
  logic [3:0] txData;
  logic       rxClk;
  logic       rxCtrl;
  logic       recvError;
  logic [3:0] rxDataPhy;
  logic       rxDataPhyOe;
  logic [3:0] rxData;
  logic       carrierSense;
  logic       colPhy;
  logic       colPhyOe;
  logic       col;

  // Wire levels from the enables and pulls
  assign txClk  = txClkPhyOe ? txClkPhy : (txClkMacOe ? txClkMac : TXCLK_PULL);
  assign rxData = rxDataPhyOe ? rxDataPhy : RXD_PULL;
  assign col    = colPhyOe ? colPhy : COL_PULL;

  modport phy_end (
    input  refClk, txClk, txCtrl, txData, rxData, col,
    output txClkPhy, txClkPhyOe, rxClk, rxCtrl, recvError,
    output rxDataPhy, rxDataPhyOe, carrierSense, colPhy, colPhyOe
  );

  modport mac_end (
    input  refClk, txClk, rxClk, rxCtrl, recvError, rxData, carrierSense, col,
    output txClkMac, txClkMacOe, txCtrl, txData
  );

endinterface : media_link_if
`default_nettype wire

/* File: rtl/media_phy_end.sv */
// Transceiver end of the MAC-side media link
`default_nettype none
module media_phy_end
  import media_pkg::*;
(
  media_link_if.phy_end  lnk,
  input  wire logic       rst,
  input  wire macMode_t   mode,
  input  wire logic       speed100,
  input  wire logic       fullDuplex,
  input  wire logic       medRxActive,
  input  wire logic [3:0] medRxData,
  input  wire logic       medRxSymErr,
  output logic            medRxTake,
  output logic            medTxStrobe,
  output logic            medTxEn,
  output logic            medTxErr,
  output logic [3:0]      medTxData,
  output logic [4:0]      mgmtAddressStrap
);

  typedef struct packed {
    strapState_t state;
    logic [4:0]  strapS1;
    logic [4:0]  strapS2;
    logic [4:0]  addr;
    logic [3:0]  divCnt;
    logic        linkClk;
    logic [3:0]  rmiiCnt;
    logic        macClkPrev;
    logic        rxDv;
    logic        rxErr;
    logic [3:0]  rxData;
    logic        rxCtrlPin;
    logic        rxTake;
    logic        txEn;
    logic        txErr;
    logic [3:0]  txData;
    logic        txStrobe;
    logic        carrier_sense;
    logic        col;
  } phyState_t;

  phyState_t  st_r;
  phyState_t  st_nxt;
  logic       isMii;
  logic       isRmii;
  logic       isRgmii;
  logic       running;
  logic       toggle;
  logic       rise;
  logic       fall;
  logic       rTick;
  logic       macRise;
  logic       macFall;
  logic       rxTick;
  logic       txTick;
  logic [3:0] laneMask;

  assign isMii    = mode == MODE_MII;
  assign isRmii   = mode == MODE_RMII;
  assign isRgmii  = mode == MODE_RGMII;
  assign running  = st_r.state == ST_RUN;
  assign laneMask = isRmii ? RMII_LANES : MII_LANES;

  assign toggle = divToggle(st_r.divCnt, speed100);
  assign rise   = toggle & ~st_r.linkClk;
  assign fall   = toggle & st_r.linkClk;
  assign rTick  = rmiiTick(st_r.rmiiCnt, speed100);

  assign macRise = lnk.txClk & ~st_r.macClkPrev;
  assign macFall = ~lnk.txClk & st_r.macClkPrev;

  assign rxTick = isRmii ? rTick : rise;
  assign txTick = isRmii ? rTick : (isRgmii ? macRise : rise);

  always_comb begin
    st_nxt          = st_r;
    st_nxt.rxTake   = 1'b0;
    st_nxt.txStrobe = 1'b0;

    st_nxt.strapS1 = {lnk.rxData, lnk.col};
    st_nxt.strapS2 = st_r.strapS1;
    unique case (st_r.state)
      ST_SETTLE: begin
        st_nxt.state = ST_WAIT;
      end
      ST_WAIT: begin
        st_nxt.state = ST_LATCH;
      end
      ST_LATCH: begin
        st_nxt.addr  = st_r.strapS2;
        st_nxt.state = ST_RUN;
      end
      ST_RUN: begin
        st_nxt.state = ST_RUN;
      end
    endcase

    st_nxt.divCnt     = toggle ? 4'h0 : st_r.divCnt + 4'h1;
    st_nxt.linkClk    = st_r.linkClk ^ toggle;
    st_nxt.rmiiCnt    = rTick ? 4'h0 : st_r.rmiiCnt + 4'h1;
    st_nxt.macClkPrev = lnk.txClk;

    if (running && rxTick) begin
      st_nxt.rxTake = 1'b1;
      st_nxt.rxDv   = medRxActive;
      st_nxt.rxErr  = medRxActive & medRxSymErr;
      if (!medRxActive) begin
        st_nxt.rxData = 4'h0;
      end else if (medRxSymErr) begin
        st_nxt.rxData = ~medRxData & laneMask;
      end else begin
        st_nxt.rxData = medRxData & laneMask;
      end
    end

    // valid on rise, error on fall
    if (isRgmii) begin
      if (rise) begin
        st_nxt.rxCtrlPin = st_nxt.rxDv;
      end else if (fall) begin
        st_nxt.rxCtrlPin = st_r.rxDv & st_r.rxErr;
      end
    end else begin
      st_nxt.rxCtrlPin = st_nxt.rxDv;
    end

    if (running && txTick) begin
      st_nxt.txEn   = lnk.txCtrl;
      st_nxt.txData = lnk.txData & laneMask;
      if (!isRgmii) begin
        st_nxt.txErr    = 1'b0;
        st_nxt.txStrobe = 1'b1;
      end
    end
    if (running && isRgmii && macFall) begin
      st_nxt.txErr    = st_r.txEn & lnk.txCtrl;
      st_nxt.txStrobe = 1'b1;
    end

    if (isMii) begin
      st_nxt.carrier_sense = running & (medRxActive | st_r.txEn);
    end else if (isRmii) begin
      st_nxt.carrier_sense = running & (medRxActive | st_r.rxDv);
    end else begin
      st_nxt.carrier_sense = 1'b0;
    end

    st_nxt.col = running & ~fullDuplex & medRxActive & st_r.txEn;
  end

  always_ff @(posedge lnk.refClk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lnk.txClkPhyOe = ~running | isMii;
  assign lnk.txClkPhy   = running & isMii & st_r.linkClk;
  assign lnk.rxClk      = running & ~isRmii & st_r.linkClk;

  assign lnk.rxCtrl       = st_r.rxCtrlPin;
  assign lnk.recvError    = st_r.rxErr & ~isRgmii;
  assign lnk.rxDataPhy    = st_r.rxData;
  assign lnk.rxDataPhyOe  = running;
  assign lnk.carrierSense = st_r.carrier_sense;
  assign lnk.colPhy       = st_r.col;
  assign lnk.colPhyOe     = running & ~isRmii;

  assign medRxTake        = st_r.rxTake;
  assign medTxStrobe      = st_r.txStrobe;
  assign medTxEn          = st_r.txEn;
  assign medTxErr         = st_r.txErr;
  assign medTxData        = st_r.txData;
  assign mgmtAddressStrap = st_r.addr;

endmodule : media_phy_end
`default_nettype wire

/* File: rtl/media_mac_end.sv */
// MAC end of the media link, with nibble crossing to the system clock
`default_nettype none
module media_mac_end
  import media_pkg::*;
(
  media_link_if.mac_end  lnk,
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire macMode_t   mode,
  input  wire logic       speed100,
  input  wire logic [3:0] txNibble,
  input  wire logic       txNibbleErr,
  input  wire logic       txNibbleValid,
  output logic            txNibbleReady,
  output logic            rxNibbleValid,
  output logic [3:0]      rxNibble,
  output logic            rxNibbleErr,
  output logic            rxBusy,
  output logic            carrierSeen,
  output logic            collisionSeen
);

  typedef struct packed {
    logic [2:0] startCnt;
    logic [3:0] divCnt;
    logic       ownClk;
    logic [3:0] rmiiCnt;
    logic       txPrev;
    logic       rxPrev;
    logic       reqS1;
    logic       reqS2;
    logic       ackTgl;
    logic       dibitHi;
    logic       txEnQ;
    logic       xmitError;
    logic [3:0] txDataQ;
    logic       ctrlPin;
    logic       rxTgl;
    logic [3:0] rxWord;
    logic       rxErrQ;
    logic [3:0] rxHold;
    logic       rxHaveLo;
    logic       rgDv;
  } linkState_t;

  typedef struct packed {
    logic       reqTgl;
    logic [3:0] hold;
    logic       holdErr;
    logic       ackS1;
    logic       ackS2;
    logic       rxS1;
    logic       rxS2;
    logic       rxSeen;
    logic [3:0] rxOut;
    logic       rxErrOut;
    logic       rxValid;
    logic [2:0] pinS1;
    logic [2:0] pinS2;
  } sysState_t;

  linkState_t lk_r;
  linkState_t lk_nxt;
  sysState_t  ck_r;
  sysState_t  ck_nxt;
  logic       isRmii;
  logic       isRgmii;
  logic       running;
  logic       toggle;
  logic       rTick;
  logic       txTick;
  logic       rxRise;
  logic       rxFall;
  logic       pending;
  logic       dGo;
  logic [3:0] dWord;
  logic       dErr;

  assign isRmii  = mode == MODE_RMII;
  assign isRgmii = mode == MODE_RGMII;
  assign running = lk_r.startCnt == MAC_START_WAIT;
  assign toggle  = divToggle(lk_r.divCnt, speed100);
  assign rTick   = rmiiTick(lk_r.rmiiCnt, speed100);
  assign rxRise  = lnk.rxClk & ~lk_r.rxPrev;
  assign rxFall  = ~lnk.rxClk & lk_r.rxPrev;
  assign txTick  = isRmii ? rTick :
                   (isRgmii ? (toggle & ~lk_r.ownClk) : (lnk.txClk & ~lk_r.txPrev));
  assign pending = ck_r.reqTgl != ck_r.ackS2;

  always_comb begin
    lk_nxt = lk_r;
    dGo    = 1'b0;
    dWord  = 4'h0;
    dErr   = 1'b0;
    if (!running) begin
      lk_nxt.startCnt = lk_r.startCnt + 3'h1;
    end
    lk_nxt.divCnt  = toggle ? 4'h0 : lk_r.divCnt + 4'h1;
    lk_nxt.ownClk  = lk_r.ownClk ^ toggle;
    lk_nxt.rmiiCnt = rTick ? 4'h0 : lk_r.rmiiCnt + 4'h1;
    lk_nxt.txPrev  = lnk.txClk;
    lk_nxt.rxPrev  = lnk.rxClk;
    lk_nxt.reqS1   = ck_r.reqTgl;
    lk_nxt.reqS2   = lk_r.reqS1;

    if (running && txTick) begin
      if (isRmii && lk_r.dibitHi) begin
        lk_nxt.txDataQ = {2'h0, ck_r.hold[3:2]};
        lk_nxt.dibitHi = 1'b0;
        lk_nxt.ackTgl  = ~lk_r.ackTgl;
      end else if (lk_r.reqS2 != lk_r.ackTgl) begin
        lk_nxt.txEnQ     = 1'b1;
        lk_nxt.xmitError = ck_r.holdErr;
        if (isRmii) begin
          lk_nxt.txDataQ = {2'h0, ck_r.hold[1:0]};
          lk_nxt.dibitHi = 1'b1;
        end else begin
          lk_nxt.txDataQ = ck_r.hold;
          lk_nxt.ackTgl  = ~lk_r.ackTgl;
        end
      end else begin
        lk_nxt.txEnQ     = 1'b0;
        lk_nxt.xmitError = 1'b0;
        lk_nxt.txDataQ   = 4'h0;
      end
    end

    // enable on rise, error on fall
    if (isRgmii) begin
      if (toggle && !lk_r.ownClk) begin
        lk_nxt.ctrlPin = lk_nxt.txEnQ;
      end else if (toggle && lk_r.ownClk) begin
        lk_nxt.ctrlPin = lk_r.txEnQ & lk_r.xmitError;
      end
    end else begin
      lk_nxt.ctrlPin = lk_nxt.txEnQ;
    end

    // Receive assembly per mode
    if (isRmii) begin
      if (rTick) begin
        if (!lnk.rxCtrl) begin
          lk_nxt.rxHaveLo = 1'b0;
        end else if (!lk_r.rxHaveLo) begin
          lk_nxt.rxHold   = {2'h0, lnk.rxData[1:0]};
          lk_nxt.rxHaveLo = 1'b1;
        end else begin
          dGo             = 1'b1;
          dWord           = {lnk.rxData[1:0], lk_r.rxHold[1:0]};
          dErr            = lnk.recvError;
          lk_nxt.rxHaveLo = 1'b0;
        end
      end
    end else if (isRgmii) begin
      if (rxRise) begin
        lk_nxt.rgDv   = lnk.rxCtrl;
        lk_nxt.rxHold = lnk.rxData;
      end else if (rxFall && lk_r.rgDv) begin
        dGo   = 1'b1;
        dWord = lk_r.rxHold;
        dErr  = lnk.rxCtrl;
      end
    end else if (rxRise && lnk.rxCtrl) begin
      dGo   = 1'b1;
      dWord = lnk.rxData;
      dErr  = lnk.recvError;
    end
    if (dGo) begin
      lk_nxt.rxWord = dWord;
      lk_nxt.rxErrQ = dErr;
      lk_nxt.rxTgl  = ~lk_r.rxTgl;
    end
  end

  always_ff @(posedge lnk.refClk or posedge rst) begin
    if (rst) begin
      lk_r <= '0;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  always_comb begin
    ck_nxt         = ck_r;
    ck_nxt.rxValid = 1'b0;
    ck_nxt.ackS1   = lk_r.ackTgl;
    ck_nxt.ackS2   = ck_r.ackS1;
    ck_nxt.rxS1    = lk_r.rxTgl;
    ck_nxt.rxS2    = ck_r.rxS1;
    ck_nxt.pinS1   = {lnk.rxCtrl, lnk.carrierSense, lnk.col};
    ck_nxt.pinS2   = ck_r.pinS1;
    if (txNibbleValid && !pending) begin
      ck_nxt.reqTgl  = ~ck_r.reqTgl;
      ck_nxt.hold    = txNibble;
      ck_nxt.holdErr = txNibbleErr;
    end
    if (ck_r.rxS2 != ck_r.rxSeen) begin
      ck_nxt.rxSeen   = ck_r.rxS2;
      ck_nxt.rxValid  = 1'b1;
      ck_nxt.rxOut    = lk_r.rxWord;
      ck_nxt.rxErrOut = lk_r.rxErrQ;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ck_r <= '0;
    end else begin
      ck_r <= ck_nxt;
    end
  end

  assign lnk.txClkMac   = lk_r.ownClk;
  assign lnk.txClkMacOe = running & isRgmii;
  assign lnk.txCtrl     = lk_r.ctrlPin;
  assign lnk.txData     = lk_r.txDataQ;

  assign txNibbleReady = ~pending;
  assign rxNibbleValid = ck_r.rxValid;
  assign rxNibble      = ck_r.rxOut;
  assign rxNibbleErr   = ck_r.rxErrOut;
  assign rxBusy        = ck_r.pinS2[2];
  assign carrierSeen   = ck_r.pinS2[1];
  assign collisionSeen = ck_r.pinS2[0];

endmodule : media_mac_end
`default_nettype wire

/* File: sim/media_link_sva.sv */
// Checker on the link pins between the two ends
`default_nettype none
module media_link_sva
  import media_pkg::*;
(
  input wire logic     refClk,
  input wire logic     rst,
  input wire macMode_t mode,
  input wire logic     speed100,
  input wire logic     fullDuplex,
  input wire logic     txClkPhyOe,
  input wire logic     txClk,
  input wire logic     rxClk,
  input wire logic     rxCtrl,
  input wire logic     recvError,
  input wire logic     rxDataPhyOe,
  input wire logic     carrierSense,
  input wire logic     colPhyOe,
  input wire logic     col
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0] txHiCnt;
  logic [3:0] rxHiCnt;

  // High-phase length of each clock pin
  always_ff @(posedge refClk or posedge rst) begin
    if (rst) begin
      txHiCnt <= 4'h0;
      rxHiCnt <= 4'h0;
    end else begin
      txHiCnt <= !txClk ? 4'h0 : ((txHiCnt == 4'hf) ? txHiCnt : txHiCnt + 4'h1);
      rxHiCnt <= !rxClk ? 4'h0 : ((rxHiCnt == 4'hf) ? rxHiCnt : rxHiCnt + 4'h1);
    end
  end

  default clocking cb @(posedge refClk); endclocking
  default disable iff (rst);

  txclk_reset_low_a: assert property (disable iff (1'b0) rst |-> txClkPhyOe && !txClk)
    else $error("transmit clock pin not low in reset");
  run_start_a: assert property ($fell(rst) |-> ##[1:4] rxDataPhyOe)
    else $error("link never left its start-up");
  tx_fast_rate_a: assert property (
    (speed100 && mode == MODE_MII && rxDataPhyOe)[*3] |-> $changed(txClk))
    else $error("transmit clock not at full rate");
  tx_slow_rate_a: assert property (
    (mode == MODE_MII && !speed100 && rxDataPhyOe && $fell(txClk))
      |-> txHiCnt == HALF_10)
    else $error("transmit clock high time wrong at low rate");
  rx_slow_rate_a: assert property (
    (mode != MODE_RMII && !speed100 && rxDataPhyOe && $fell(rxClk))
      |-> rxHiCnt == HALF_10)
    else $error("receive clock high time wrong at low rate");
  rmii_clk_idle_a: assert property (
    (mode == MODE_RMII && rxDataPhyOe) |-> !rxClk && !txClkPhyOe)
    else $error("nibble clocks active in reduced mode");
  rgmii_unused_a: assert property (mode == MODE_RGMII |-> !recvError && !carrierSense)
    else $error("unused pins active in reduced gigabit mode");
  col_rules_a: assert property (
    colPhyOe |-> mode != MODE_RMII && !(fullDuplex && col))
    else $error("collision in full duplex or reduced mode");
  err_in_frame_a: assert property ((mode != MODE_RGMII && recvError) |-> rxCtrl)
    else $error("receive error outside a frame");
  rmii_merge_a: assert property ((mode == MODE_RMII && rxCtrl) |-> carrierSense)
    else $error("merged carrier low while data valid");
endmodule : media_link_sva
`default_nettype wire

/* File: sim/phy_mac_side_media_interface_tb_top.sv */
// Bench joining the transceiver end and the MAC end
`default_nettype none
module phy_mac_side_media_interface_tb_top
  import media_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk, refClk, rst, speed100, fullDuplex;
  macMode_t    mode;
  logic        medRxActive, medRxSymErr, medRxTake, medTxStrobe, medTxEn, medTxErr;
  logic [3:0]  medRxData, medTxData, txNibble, rxNibble;
  logic [4:0]  mgmtAddressStrap;
  logic        txNibbleErr, txNibbleValid, txNibbleReady, rxNibbleValid, rxNibbleErr;
  logic        rxBusy, carrierSeen, collisionSeen, crsHit, colHit, busyHit;
  logic [16:0] seed;
  logic [4:0]  txQ[$], rxQ[$], expW;
  int          failCount, totalChecks;

  media_link_if media_link_if_inst (.refClk(refClk));
  media_phy_end media_phy_end_inst (.lnk(media_link_if_inst), .rst(rst), .mode(mode),
    .speed100(speed100), .fullDuplex(fullDuplex), .medRxActive(medRxActive),
    .medRxData(medRxData), .medRxSymErr(medRxSymErr), .medRxTake(medRxTake),
    .medTxStrobe(medTxStrobe), .medTxEn(medTxEn), .medTxErr(medTxErr),
    .medTxData(medTxData), .mgmtAddressStrap(mgmtAddressStrap));
  media_mac_end media_mac_end_inst (.lnk(media_link_if_inst), .clk(clk), .rst(rst),
    .mode(mode), .speed100(speed100), .txNibble(txNibble), .txNibbleErr(txNibbleErr),
    .txNibbleValid(txNibbleValid), .txNibbleReady(txNibbleReady),
    .rxNibbleValid(rxNibbleValid), .rxNibble(rxNibble), .rxNibbleErr(rxNibbleErr),
    .rxBusy(rxBusy), .carrierSeen(carrierSeen), .collisionSeen(collisionSeen));
  media_link_sva media_link_sva_inst (.refClk(refClk), .rst(rst), .mode(mode),
    .speed100(speed100), .fullDuplex(fullDuplex),
    .txClkPhyOe(media_link_if_inst.txClkPhyOe), .txClk(media_link_if_inst.txClk),
    .rxClk(media_link_if_inst.rxClk), .rxCtrl(media_link_if_inst.rxCtrl),
    .recvError(media_link_if_inst.recvError), .rxDataPhyOe(media_link_if_inst.rxDataPhyOe),
    .carrierSense(media_link_if_inst.carrierSense),
    .colPhyOe(media_link_if_inst.colPhyOe), .col(media_link_if_inst.col));

  always #4 clk = ~clk;
  initial begin
    refClk = 1'b0;
    #1.7;
    forever #3 refClk = ~refClk;
  end

  function automatic logic [4:0] txExpect(input logic [3:0] d, input logic e);
    return {e && (mode == MODE_RGMII), d};
  endfunction : txExpect

  function automatic logic [4:0] rxExpect(input logic [3:0] d, input logic e);
    return {e, e ? ~d : d};
  endfunction : rxExpect

  function automatic logic [16:0] lfsrStep(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsrStep

  task automatic nextRand(output logic [3:0] r);
    seed = lfsrStep(seed);
    r = seed[3:0];
  endtask : nextRand

  task automatic chkWord(input logic [4:0] got, input logic [4:0] exp, input string what);
    totalChecks++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chkWord

  task automatic chkFlag(input logic got, input logic exp, input string what);
    chkWord({4'h0, got}, {4'h0, exp}, what);
  endtask : chkFlag

  task automatic printVerdict();
    if (failCount == 0 && totalChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : printVerdict

  always @(negedge refClk) begin
    if (!rst && medTxStrobe === 1'b1 && medTxEn === 1'b1) begin
      expW = (txQ.size() != 0) ? txQ.pop_front() : 5'hx;
      chkWord({medTxErr, medTxData}, expW, "sent word");
    end
  end

  always @(negedge clk) begin
    if (!rst && rxNibbleValid === 1'b1) begin
      expW = (rxQ.size() != 0) ? rxQ.pop_front() : 5'hx;
      chkWord({rxNibbleErr, rxNibble}, expW, "received word");
    end
    if (carrierSeen === 1'b1) crsHit = 1'b1;
    if (collisionSeen === 1'b1) colHit = 1'b1;
    if (rxBusy === 1'b1) busyHit = 1'b1;
  end

  task automatic sendWords(input int n);
    logic [3:0] d;
    for (int i = 0; i < n; i++) begin
      nextRand(d);
      txNibble = d;
      txNibbleErr = (i == 2);
      txNibbleValid = 1'b1;
      while (txNibbleReady !== 1'b1) @(negedge clk);
      if (mode == MODE_RMII) begin
        txQ.push_back(txExpect({2'h0, d[1:0]}, txNibbleErr));
        txQ.push_back(txExpect({2'h0, d[3:2]}, txNibbleErr));
      end else begin
        txQ.push_back(txExpect(d, txNibbleErr));
      end
      @(negedge clk);
    end
    txNibbleValid = 1'b0;
  endtask : sendWords

  task automatic recvFrame(input int n);
    logic [3:0] d;
    logic [4:0] w;
    logic [1:0] lo;
    @(negedge refClk);
    medRxActive = 1'b1;
    for (int i = 0; i < n; i++) begin
      nextRand(d);
      medRxData = d;
      medRxSymErr = (i == 3);
      @(negedge refClk);
      while (medRxTake !== 1'b1) @(negedge refClk);
      w = rxExpect(d, medRxSymErr);
      // two dibits make one nibble in RMII
      if (mode != MODE_RMII) begin
        rxQ.push_back(w);
      end else if (i[0]) begin
        rxQ.push_back({w[4], w[1:0], lo});
      end else begin
        lo = w[1:0];
      end
    end
    medRxActive = 1'b0;
    medRxSymErr = 1'b0;
  endtask : recvFrame

  task automatic runCase(input macMode_t m, input logic s);
    logic [3:0] r;
    rst = 1'b1;
    mode = m;
    speed100 = s;
    nextRand(r);
    fullDuplex = r[0];
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (10) @(negedge clk);
    chkWord(mgmtAddressStrap, 5'h01, "strap address");
    crsHit = 1'b0;
    colHit = 1'b0;
    busyHit = 1'b0;
    if (s) begin
      sendWords(12);
    end else begin
      fork
        sendWords(10);
        recvFrame(8);
      join
    end
    for (int k = 0; k < 3000 && (txQ.size() + rxQ.size()) != 0; k++) @(negedge clk);
    chkWord(5'(txQ.size()), 5'h00, "words not sent");
    chkWord(5'(rxQ.size()), 5'h00, "words not received");
    if (!s) begin
      chkFlag(crsHit, m != MODE_RGMII, "carrier seen");
      chkFlag(busyHit, 1'b1, "receive busy seen");
      if (m != MODE_RMII) chkFlag(colHit, !fullDuplex, "collision seen");
    end
  endtask : runCase

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    mode = MODE_MII;
    speed100 = 1'b1;
    fullDuplex = 1'b1;
    medRxActive = 1'b0;
    medRxData = 4'h0;
    medRxSymErr = 1'b0;
    txNibble = 4'h0;
    txNibbleErr = 1'b0;
    txNibbleValid = 1'b0;
    seed = 17'h1658f;
    failCount = 0;
    totalChecks = 0;
    for (int i = 0; i < 6; i++) runCase(macMode_t'(i / 2), i[0]);
    printVerdict();
  end

  initial begin
    #200000;
    failCount++;
    printVerdict();
  end
endmodule : phy_mac_side_media_interface_tb_top
`default_nettype wire
